// file: src/cbsw_branch_unit.sv
// Branch timing, operand addressing and status word register
`timescale 1ns/1ps
module cbsw_branch_unit (
	input  wire logic                   core_clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   dec_valid_i,
	input  wire logic [7:0]             opcode_i,
	input  wire logic [7:0]             operand1_i,
	input  wire logic [7:0]             operand2_i,
	input  wire logic [15:0]            instr_addr_i,
	input  wire logic [7:0]             acc_i,
	input  wire logic [7:0]             opnd_val_i,
	input  wire logic [7:0]             ptr_val_i,
	input  wire logic                   alu_valid_i,
	input  wire cbsw_pkg::cbsw_alu_op_t alu_op_i,
	input  wire logic [7:0]             alu_a_i,
	input  wire logic [7:0]             alu_b_i,
	input  wire logic [7:0]             sf_addr_i,
	input  wire logic                   sf_wr_i,
	input  wire logic                   sf_rd_i,
	input  wire logic [7:0]             sf_wdata_i,
	output logic                        busy_o,
	output logic                        done_o,
	output logic                        known_o,
	output logic [1:0]                  instr_len_o,
	output logic [2:0]                  cycles_o,
	output logic                        taken_o,
	output logic [15:0]                 target_o,
	output logic [15:0]                 next_pc_o,
	output logic [7:0]                  op_addr_o,
	output logic                        op_is_special_o,
	output logic [7:0]                  ptr_reg_addr_o,
	output logic [7:0]                  dec_result_o,
	output logic [7:0]                  sf_rdata_o,
	output logic [7:0]                  status_word_o
);

	logic [7:0]  status_q;
	logic [7:0]  status_d;
	logic [7:0]  rdata_q;
	logic        busy_q;
	logic        done_q;
	logic [2:0]  cnt_q;
	logic        known_q;
	logic [1:0]  len_q;
	logic [2:0]  cyc_q;
	logic        taken_q;
	logic [15:0] target_q;
	logic [15:0] next_pc_q;
	logic [7:0]  op_addr_q;
	logic        special_q;
	logic [7:0]  ptr_q;
	logic [7:0]  dec_q;

	logic        known_d;
	logic [1:0]  len_d;
	logic [2:0]  cyc_nt;
	logic [2:0]  cyc_tk;
	logic [2:0]  cyc_d;
	logic        taken_d;
	logic [15:0] target_d;
	logic [15:0] next_pc_d;
	logic [7:0]  op_addr_d;
	logic        special_d;
	logic [7:0]  ptr_d;
	logic [7:0]  dec_d;
	logic [1:0]  bank;
	logic        accept;

	logic        f_carry;
	logic        f_aux;
	logic        f_ovf;
	logic        u_carry;
	logic        u_aux;
	logic        u_ovf;

	// Signed relative branch target
	function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [7:0] rel);
		rel_target = base + {{8{rel[7]}}, rel};
	endfunction : rel_target

	// Address following the instruction
	function automatic logic [15:0] after_instr(input logic [15:0] pc, input logic [1:0] n);
		after_instr = pc + {14'h0000, n};
	endfunction : after_instr

	// Data address of a working register in a bank
	function automatic logic [7:0] bank_reg(input logic [1:0] bk, input logic [2:0] idx);
		bank_reg = {3'b000, bk, idx};
	endfunction : bank_reg

	assign bank   = {status_q[cbsw_pkg::BANK_HIGH_BIT], status_q[cbsw_pkg::BANK_LOW_BIT]};
	assign accept = dec_valid_i && !busy_q;

	// Instruction decode
	always_comb
	begin
		known_d   = 1'b1;
		len_d     = cbsw_pkg::LEN_ONE;
		cyc_nt    = cbsw_pkg::CYC_SINGLE;
		cyc_tk    = cbsw_pkg::CYC_SINGLE;
		taken_d   = 1'b0;
		op_addr_d = 8'h00;
		special_d = 1'b0;
		ptr_d     = 8'h00;
		dec_d     = 8'h00;
		next_pc_d = after_instr(instr_addr_i, cbsw_pkg::LEN_ONE);
		target_d  = next_pc_d;
		casez (opcode_i)
			cbsw_pkg::OP_NO_OPERATION, cbsw_pkg::OP_UNUSED:
			begin
				len_d = cbsw_pkg::LEN_ONE;
			end
			cbsw_pkg::OP_JUMP_ACC_NZ:
			begin
				len_d     = cbsw_pkg::LEN_TWO;
				cyc_nt    = cbsw_pkg::CYC_ACC_NT;
				cyc_tk    = cbsw_pkg::CYC_ACC_TK;
				next_pc_d = after_instr(instr_addr_i, len_d);
				taken_d   = (acc_i != 8'h00);
				target_d  = rel_target(next_pc_d, operand1_i);
			end
			cbsw_pkg::OP_SHORT_JUMP:
			begin
				len_d     = cbsw_pkg::LEN_TWO;
				cyc_nt    = cbsw_pkg::CYC_SHORT_JUMP;
				cyc_tk    = cbsw_pkg::CYC_SHORT_JUMP;
				next_pc_d = after_instr(instr_addr_i, len_d);
				taken_d   = 1'b1;
				target_d  = rel_target(next_pc_d, operand1_i);
			end
			cbsw_pkg::OP_CMP_ACC_DIRECT:
			begin
				len_d     = cbsw_pkg::LEN_THREE;
				cyc_nt    = cbsw_pkg::CYC_CMP_NT;
				cyc_tk    = cbsw_pkg::CYC_CMP_TK;
				next_pc_d = after_instr(instr_addr_i, len_d);
				op_addr_d = operand1_i;
				special_d = operand1_i[cbsw_pkg::SPECIAL_FUNC_BIT];
				taken_d   = (acc_i != opnd_val_i);
				target_d  = rel_target(next_pc_d, operand2_i);
			end
			cbsw_pkg::OP_CMP_ACC_IMM:
			begin
				len_d     = cbsw_pkg::LEN_THREE;
				cyc_nt    = cbsw_pkg::CYC_CMP_NT;
				cyc_tk    = cbsw_pkg::CYC_CMP_TK;
				next_pc_d = after_instr(instr_addr_i, len_d);
				taken_d   = (acc_i != operand1_i);
				target_d  = rel_target(next_pc_d, operand2_i);
			end
			cbsw_pkg::OP_CMP_INDIRECT:
			begin
				len_d     = cbsw_pkg::LEN_THREE;
				cyc_nt    = cbsw_pkg::CYC_CMP_IND_NT;
				cyc_tk    = cbsw_pkg::CYC_CMP_IND_TK;
				next_pc_d = after_instr(instr_addr_i, len_d);
				ptr_d     = bank_reg(bank, {2'b00, opcode_i[0]});
				op_addr_d = ptr_val_i;
				taken_d   = (opnd_val_i != operand1_i);
				target_d  = rel_target(next_pc_d, operand2_i);
			end
			cbsw_pkg::OP_CMP_REGISTER:
			begin
				len_d     = cbsw_pkg::LEN_THREE;
				cyc_nt    = cbsw_pkg::CYC_CMP_NT;
				cyc_tk    = cbsw_pkg::CYC_CMP_TK;
				next_pc_d = after_instr(instr_addr_i, len_d);
				op_addr_d = bank_reg(bank, opcode_i[2:0]);
				taken_d   = (opnd_val_i != operand1_i);
				target_d  = rel_target(next_pc_d, operand2_i);
			end
			cbsw_pkg::OP_DEC_REGISTER:
			begin
				len_d     = cbsw_pkg::LEN_TWO;
				cyc_nt    = cbsw_pkg::CYC_DEC_REG_NT;
				cyc_tk    = cbsw_pkg::CYC_DEC_REG_TK;
				next_pc_d = after_instr(instr_addr_i, len_d);
				op_addr_d = bank_reg(bank, opcode_i[2:0]);
				dec_d     = opnd_val_i - 8'h01;
				taken_d   = (dec_d != 8'h00);
				target_d  = rel_target(next_pc_d, operand1_i);
			end
			cbsw_pkg::OP_DEC_DIRECT:
			begin
				len_d     = cbsw_pkg::LEN_THREE;
				cyc_nt    = cbsw_pkg::CYC_DEC_DIR_NT;
				cyc_tk    = cbsw_pkg::CYC_DEC_DIR_TK;
				next_pc_d = after_instr(instr_addr_i, len_d);
				op_addr_d = operand1_i;
				special_d = operand1_i[cbsw_pkg::SPECIAL_FUNC_BIT];
				dec_d     = opnd_val_i - 8'h01;
				taken_d   = (dec_d != 8'h00);
				target_d  = rel_target(next_pc_d, operand2_i);
			end
			cbsw_pkg::OP_PAGE_JUMP, cbsw_pkg::OP_PAGE_CALL:
			begin
				len_d     = cbsw_pkg::LEN_TWO;
				cyc_nt    = cbsw_pkg::CYC_PAGE_XFER;
				cyc_tk    = cbsw_pkg::CYC_PAGE_XFER;
				next_pc_d = after_instr(instr_addr_i, len_d);
				taken_d   = 1'b1;
				target_d  = {next_pc_d[15:cbsw_pkg::PAGE_BITS], opcode_i[7:5], operand1_i};
			end
			cbsw_pkg::OP_LONG_JUMP, cbsw_pkg::OP_LONG_CALL:
			begin
				len_d     = cbsw_pkg::LEN_THREE;
				cyc_nt    = cbsw_pkg::CYC_LONG_XFER;
				cyc_tk    = cbsw_pkg::CYC_LONG_XFER;
				next_pc_d = after_instr(instr_addr_i, len_d);
				taken_d   = 1'b1;
				target_d  = {operand1_i, operand2_i};
			end
			default:
			begin
				known_d = 1'b0;
			end
		endcase
		cyc_d = taken_d ? cyc_tk : cyc_nt;
	end

	// Cycle sequencer
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			cnt_q  <= 3'h0;
		end
		else if (accept)
		begin
			busy_q <= 1'b1;
			cnt_q  <= cyc_d - 3'h1;
			done_q <= (cyc_d == cbsw_pkg::CYC_SINGLE);
		end
		else if (busy_q)
		begin
			if (cnt_q == 3'h0)
			begin
				busy_q <= 1'b0;
				done_q <= 1'b0;
			end
			else
			begin
				cnt_q  <= cnt_q - 3'h1;
				done_q <= (cnt_q == 3'h1);
			end
		end
	end

	// Decode results captured at acceptance
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			known_q   <= 1'b0;
			len_q     <= 2'h0;
			cyc_q     <= 3'h0;
			taken_q   <= 1'b0;
			target_q  <= 16'h0000;
			next_pc_q <= 16'h0000;
			op_addr_q <= 8'h00;
			special_q <= 1'b0;
			ptr_q     <= 8'h00;
			dec_q     <= 8'h00;
		end
		else if (accept)
		begin
			known_q   <= known_d;
			len_q     <= len_d;
			cyc_q     <= cyc_d;
			taken_q   <= taken_d;
			target_q  <= target_d;
			next_pc_q <= next_pc_d;
			op_addr_q <= op_addr_d;
			special_q <= special_d;
			ptr_q     <= ptr_d;
			dec_q     <= dec_d;
		end
	end

	cbsw_flag_calc u_flags (
		.op_i        (alu_op_i),
		.a_i         (alu_a_i),
		.b_i         (alu_b_i),
		.carry_in_i  (status_q[cbsw_pkg::CARRY_BIT]),
		.carry_o     (f_carry),
		.aux_o       (f_aux),
		.ovf_o       (f_ovf),
		.upd_carry_o (u_carry),
		.upd_aux_o   (u_aux),
		.upd_ovf_o   (u_ovf)
	);

	// Status word next value
	always_comb
	begin
		status_d = status_q;
		if (sf_wr_i && (sf_addr_i == cbsw_pkg::STATUS_ADDR))
		begin
			status_d = sf_wdata_i;
		end
		if (alu_valid_i && u_carry)
		begin
			status_d[cbsw_pkg::CARRY_BIT] = f_carry;
		end
		if (alu_valid_i && u_aux)
		begin
			status_d[cbsw_pkg::AUX_CARRY_BIT] = f_aux;
		end
		if (alu_valid_i && u_ovf)
		begin
			status_d[cbsw_pkg::OVERFLOW_BIT] = f_ovf;
		end
		status_d[cbsw_pkg::PARITY_BIT] = ^acc_i;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			status_q <= cbsw_pkg::STATUS_RESET;
		end
		else
		begin
			status_q <= status_d;
		end
	end

	// Register read port
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			rdata_q <= 8'h00;
		end
		else if (sf_rd_i)
		begin
			rdata_q <= (sf_addr_i == cbsw_pkg::STATUS_ADDR) ? status_q : 8'h00;
		end
	end

	assign busy_o          = busy_q;
	assign done_o          = done_q;
	assign known_o         = known_q;
	assign instr_len_o     = len_q;
	assign cycles_o        = cyc_q;
	assign taken_o         = taken_q;
	assign target_o        = target_q;
	assign next_pc_o       = next_pc_q;
	assign op_addr_o       = op_addr_q;
	assign op_is_special_o = special_q;
	assign ptr_reg_addr_o  = ptr_q;
	assign dec_result_o    = dec_q;
	assign sf_rdata_o      = rdata_q;
	assign status_word_o   = status_q;

endmodule : cbsw_branch_unit

// file: src/cbsw_pkg.sv
// Constants and types for the branch timing and status word unit
// Overview of operation
// - jump_acc_nonzero: two bytes, 2 or 3 cycles
// - compare_jump_unequal: three bytes, 3/4, indirect 4/5
// - decrement_jump_nonzero: register 2/3, direct 3/4
// - Unused opcode acts as one-cycle no_operation
// - Working register picked within current bank
// - Indirect pointer is bank register zero or one
// - Relative target is next address plus signed offset
// - Direct address upper half means special function
// - Page-local targets replace low eleven bits only
// - Long call and jump load sixteen bit target
// - Bank select picks one of four banks
package cbsw_pkg;

	// Status word location and layout
	localparam logic [7:0] STATUS_ADDR      = 8'hD0;
	localparam logic [7:0] STATUS_RESET     = 8'h00;
	localparam int         CARRY_BIT        = 7;
	localparam int         AUX_CARRY_BIT    = 6;
	localparam int         BANK_HIGH_BIT    = 4;
	localparam int         BANK_LOW_BIT     = 3;
	localparam int         OVERFLOW_BIT     = 2;
	localparam int         PARITY_BIT       = 0;
	localparam int         SPECIAL_FUNC_BIT = 7;
	localparam int         PAGE_BITS        = 11;

	// Opcodes
	localparam logic [7:0] OP_NO_OPERATION   = 8'h00;
	localparam logic [7:0] OP_UNUSED         = 8'hA5;
	localparam logic [7:0] OP_JUMP_ACC_NZ    = 8'h70;
	localparam logic [7:0] OP_SHORT_JUMP     = 8'h80;
	localparam logic [7:0] OP_CMP_ACC_DIRECT = 8'hB5;
	localparam logic [7:0] OP_CMP_ACC_IMM    = 8'hB4;
	localparam logic [7:0] OP_CMP_INDIRECT   = 8'b1011_011?;
	localparam logic [7:0] OP_CMP_REGISTER   = 8'b1011_1???;
	localparam logic [7:0] OP_DEC_REGISTER   = 8'b1101_1???;
	localparam logic [7:0] OP_DEC_DIRECT     = 8'hD5;
	localparam logic [7:0] OP_PAGE_JUMP      = 8'b???0_0001;
	localparam logic [7:0] OP_PAGE_CALL      = 8'b???1_0001;
	localparam logic [7:0] OP_LONG_JUMP      = 8'h02;
	localparam logic [7:0] OP_LONG_CALL      = 8'h12;

	// Instruction lengths in bytes
	localparam logic [1:0] LEN_ONE   = 2'h1;
	localparam logic [1:0] LEN_TWO   = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;

	// Cycle counts, not taken and taken
	localparam logic [2:0] CYC_SINGLE      = 3'h1;
	localparam logic [2:0] CYC_ACC_NT      = 3'h2;
	localparam logic [2:0] CYC_ACC_TK      = 3'h3;
	localparam logic [2:0] CYC_CMP_NT      = 3'h3;
	localparam logic [2:0] CYC_CMP_TK      = 3'h4;
	localparam logic [2:0] CYC_CMP_IND_NT  = 3'h4;
	localparam logic [2:0] CYC_CMP_IND_TK  = 3'h5;
	localparam logic [2:0] CYC_DEC_REG_NT  = 3'h2;
	localparam logic [2:0] CYC_DEC_REG_TK  = 3'h3;
	localparam logic [2:0] CYC_DEC_DIR_NT  = 3'h3;
	localparam logic [2:0] CYC_DEC_DIR_TK  = 3'h4;
	localparam logic [2:0] CYC_SHORT_JUMP  = 3'h3;
	localparam logic [2:0] CYC_PAGE_XFER   = 3'h3;
	localparam logic [2:0] CYC_LONG_XFER   = 3'h4;

	// Arithmetic operations; all but ALU_NONE touch the flags
	typedef enum logic [2:0] {
		ALU_NONE,
		ALU_ADD,
		ALU_ADD_CARRY,
		ALU_SUB_BORROW,
		ALU_MULTIPLY,
		ALU_DIVIDE,
		ALU_OTHER
	} cbsw_alu_op_t;

endpackage : cbsw_pkg

// file: src/cbsw_flag_calc.sv
// Arithmetic flag computation for the status word
`timescale 1ns/1ps
module cbsw_flag_calc (
	input  wire cbsw_pkg::cbsw_alu_op_t op_i,
	input  wire logic [7:0]             a_i,
	input  wire logic [7:0]             b_i,
	input  wire logic                   carry_in_i,
	output logic                        carry_o,
	output logic                        aux_o,
	output logic                        ovf_o,
	output logic                        upd_carry_o,
	output logic                        upd_aux_o,
	output logic                        upd_ovf_o
);

	logic        cin;
	logic [8:0]  sum;
	logic [8:0]  diff;
	logic [4:0]  nib_sum;
	logic [4:0]  nib_diff;
	logic [15:0] prod;

	assign cin      = (op_i == cbsw_pkg::ALU_NONE || op_i == cbsw_pkg::ALU_ADD) ? 1'b0
	                : carry_in_i;
	assign sum      = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
	assign diff     = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin};
	assign nib_sum  = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
	assign nib_diff = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin};
	assign prod     = {8'h00, a_i} * {8'h00, b_i};

	always_comb
	begin
		carry_o     = 1'b0;
		aux_o       = 1'b0;
		ovf_o       = 1'b0;
		upd_carry_o = 1'b0;
		upd_aux_o   = 1'b0;
		upd_ovf_o   = 1'b0;
		case (op_i)
			cbsw_pkg::ALU_ADD, cbsw_pkg::ALU_ADD_CARRY:
			begin
				carry_o     = sum[8];
				aux_o       = nib_sum[4];
				ovf_o       = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
				upd_carry_o = 1'b1;
				upd_aux_o   = 1'b1;
				upd_ovf_o   = 1'b1;
			end
			cbsw_pkg::ALU_SUB_BORROW:
			begin
				carry_o     = diff[8];
				aux_o       = nib_diff[4];
				ovf_o       = (a_i[7] != b_i[7]) && (diff[7] != a_i[7]);
				upd_carry_o = 1'b1;
				upd_aux_o   = 1'b1;
				upd_ovf_o   = 1'b1;
			end
			cbsw_pkg::ALU_MULTIPLY:
			begin
				ovf_o       = (prod[15:8] != 8'h00);
				upd_carry_o = 1'b1;
				upd_ovf_o   = 1'b1;
			end
			cbsw_pkg::ALU_DIVIDE:
			begin
				ovf_o       = (b_i == 8'h00);
				upd_carry_o = 1'b1;
				upd_ovf_o   = 1'b1;
			end
			cbsw_pkg::ALU_OTHER:
			begin
				upd_carry_o = 1'b1;
			end
			default:
			begin
				upd_carry_o = 1'b0;
			end
		endcase
	end

endmodule : cbsw_flag_calc

// file: testbench/cbsw_branch_unit_asserts.sv
// Concurrent checks on the branch timing and status word unit
`timescale 1ns/1ps
module cbsw_branch_unit_chk (
	input wire logic                   core_clk_i,
	input wire logic                   resetn_i,
	input wire logic                   dec_valid_i,
	input wire logic [7:0]             opcode_i,
	input wire logic [7:0]             operand1_i,
	input wire logic [7:0]             operand2_i,
	input wire logic [15:0]            instr_addr_i,
	input wire logic [7:0]             acc_i,
	input wire logic                   alu_valid_i,
	input wire cbsw_pkg::cbsw_alu_op_t alu_op_i,
	input wire logic [7:0]             alu_a_i,
	input wire logic [7:0]             alu_b_i,
	input wire logic                   busy_o,
	input wire logic                   done_o,
	input wire logic [1:0]             instr_len_o,
	input wire logic [2:0]             cycles_o,
	input wire logic                   taken_o,
	input wire logic [15:0]            target_o,
	input wire logic [15:0]            next_pc_o,
	input wire logic [7:0]             op_addr_o,
	input wire logic                   op_is_special_o,
	input wire logic [7:0]             ptr_reg_addr_o,
	input wire logic [7:0]             status_word_o
);
	logic        take;
	logic [15:0] rel_ext;
	logic [10:0] page_low;
	logic [7:0]  bank_reg;
	logic [7:0]  ptr_reg;
	logic [8:0]  add_sum;
	assign take = dec_valid_i && !busy_o;
	assign rel_ext = {{8{operand1_i[7]}}, operand1_i};
	assign page_low = {opcode_i[7:5], operand1_i};
	assign bank_reg = {3'h0, status_word_o[4:3], opcode_i[2:0]};
	assign ptr_reg = {3'h0, status_word_o[4:3], 2'h0, opcode_i[0]};
	assign add_sum = {1'b0, alu_a_i} + {1'b0, alu_b_i};

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	property p_nop_timing;
		take && (opcode_i == 8'h00 || opcode_i == 8'hA5) |=>
			instr_len_o == 2'h1 && cycles_o == 3'h1 && done_o && !taken_o;
	endproperty
	a_nop_timing: assert property (p_nop_timing) else $error("no-op timing wrong");
	property p_acc_timing;
		take && opcode_i == 8'h70 |=>
			instr_len_o == 2'h2 && cycles_o == (($past(acc_i) != 8'h00) ? 3'h3 : 3'h2);
	endproperty
	a_acc_timing: assert property (p_acc_timing) else $error("acc jump timing wrong");
	property p_rel_target;
		take && (opcode_i == 8'h70 || opcode_i == 8'h80) |=>
			target_o == $past(instr_addr_i) + 16'h0002 + $past(rel_ext);
	endproperty
	a_rel_target: assert property (p_rel_target) else $error("relative target wrong");
	property p_page_target;
		take && opcode_i[3:0] == 4'h1 |=> target_o[15:11] == next_pc_o[15:11]
			&& target_o[10:0] == $past(page_low);
	endproperty
	a_page_target: assert property (p_page_target) else $error("page target wrong");
	property p_long_target;
		take && (opcode_i == 8'h02 || opcode_i == 8'h12) |=>
			target_o == {$past(operand1_i), $past(operand2_i)} && instr_len_o == 2'h3;
	endproperty
	a_long_target: assert property (p_long_target) else $error("long target wrong");
	property p_busy_run;
		$rose(busy_o) && cycles_o == 3'h5 |-> busy_o [*5] ##1 !busy_o;
	endproperty
	a_busy_run: assert property (p_busy_run) else $error("busy length wrong");
	property p_done_last;
		done_o |-> busy_o ##1 !busy_o;
	endproperty
	a_done_last: assert property (p_done_last) else $error("done not last");
	property p_bank_reg;
		take && opcode_i[7:3] == 5'h1B |=> op_addr_o == $past(bank_reg);
	endproperty
	a_bank_reg: assert property (p_bank_reg) else $error("bank register wrong");
	property p_ptr_reg;
		take && opcode_i[7:1] == 7'h5B |=> ptr_reg_addr_o == $past(ptr_reg);
	endproperty
	a_ptr_reg: assert property (p_ptr_reg) else $error("pointer register wrong");
	property p_special;
		take && opcode_i == 8'hD5 |=> op_is_special_o == ($past(operand1_i) >= 8'h80);
	endproperty
	a_special: assert property (p_special) else $error("special select wrong");
	property p_add_carry;
		alu_valid_i && alu_op_i == cbsw_pkg::ALU_ADD |=>
			status_word_o[7] == ($past(add_sum) >= 9'h100);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry wrong");
	property p_div_ovf;
		alu_valid_i && alu_op_i == cbsw_pkg::ALU_DIVIDE |=>
			status_word_o[2] == ($past(alu_b_i) == 8'h00) && !status_word_o[7];
	endproperty
	a_div_ovf: assert property (p_div_ovf) else $error("divide flags wrong");
endmodule : cbsw_branch_unit_chk

bind cbsw_branch_unit cbsw_branch_unit_chk u_chk (.*);

// file: testbench/cbsw_branch_unit_tb.sv
// Self-checking bench for the branch timing and status word unit
`timescale 1ns/1ps
module cbsw_branch_unit_tb;
	typedef struct packed {
		logic [7:0]  opc, o1, o2, acc, val;
		logic [15:0] addr;
		logic [1:0]  len;
		logic [2:0]  cyc;
		logic        tk;
		logic [15:0] tgt;
	} cbsw_row_t;

	logic                   core_clk_i, resetn_i, dec_valid_i, alu_valid_i, sf_wr_i, sf_rd_i;
	logic [7:0]             opcode_i, operand1_i, operand2_i, acc_i, opnd_val_i, ptr_val_i;
	logic [15:0]            instr_addr_i, target_o, next_pc_o;
	cbsw_pkg::cbsw_alu_op_t alu_op_i;
	logic [7:0]             alu_a_i, alu_b_i, sf_addr_i, sf_wdata_i, sf_rdata_o;
	logic                   busy_o, done_o, known_o, taken_o, op_is_special_o;
	logic [1:0]             instr_len_o;
	logic [2:0]             cycles_o;
	logic [7:0]             op_addr_o, ptr_reg_addr_o, dec_result_o, status_word_o;
	int                     bad_count = 0;
	int                     comparisons = 0;
	cbsw_row_t              rows [18] = '{
		'{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h1000, 2'h1, 3'h1, 1'b0, 16'h1001},
		'{8'hA5, 8'h00, 8'h00, 8'h00, 8'h00, 16'h1000, 2'h1, 3'h1, 1'b0, 16'h1001},
		'{8'h70, 8'h10, 8'h00, 8'h05, 8'h00, 16'h1000, 2'h2, 3'h3, 1'b1, 16'h1012},
		'{8'h70, 8'hF0, 8'h00, 8'h00, 8'h00, 16'h1000, 2'h2, 3'h2, 1'b0, 16'h0FF2},
		'{8'hB5, 8'h00, 8'h80, 8'h03, 8'h03, 16'h1000, 2'h3, 3'h3, 1'b0, 16'h0F83},
		'{8'hB4, 8'h04, 8'h7F, 8'h03, 8'h00, 16'h1000, 2'h3, 3'h4, 1'b1, 16'h1082},
		'{8'hB6, 8'h09, 8'h02, 8'h00, 8'h09, 16'h1000, 2'h3, 3'h4, 1'b0, 16'h1005},
		'{8'hB7, 8'h02, 8'hFE, 8'h00, 8'h01, 16'h1000, 2'h3, 3'h5, 1'b1, 16'h1001},
		'{8'hBB, 8'h05, 8'h01, 8'h00, 8'h04, 16'h1000, 2'h3, 3'h4, 1'b1, 16'h1004},
		'{8'hDB, 8'h05, 8'h00, 8'h00, 8'h01, 16'h1000, 2'h2, 3'h2, 1'b0, 16'h1007},
		'{8'hDB, 8'hFE, 8'h00, 8'h00, 8'h00, 16'h1000, 2'h2, 3'h3, 1'b1, 16'h1000},
		'{8'hD5, 8'h90, 8'h10, 8'h00, 8'h02, 16'h1000, 2'h3, 3'h4, 1'b1, 16'h1013},
		'{8'hD5, 8'h20, 8'h10, 8'h00, 8'h01, 16'h1000, 2'h3, 3'h3, 1'b0, 16'h1013},
		'{8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 16'h1000, 2'h2, 3'h3, 1'b1, 16'h0F82},
		'{8'hE1, 8'h34, 8'h00, 8'h00, 8'h00, 16'h27FE, 2'h2, 3'h3, 1'b1, 16'h2F34},
		'{8'h11, 8'hAB, 8'h00, 8'h00, 8'h00, 16'h1000, 2'h2, 3'h3, 1'b1, 16'h10AB},
		'{8'h02, 8'h12, 8'h34, 8'h00, 8'h00, 16'h1000, 2'h3, 3'h4, 1'b1, 16'h1234},
		'{8'h12, 8'hFF, 8'hFE, 8'h00, 8'h00, 16'h1000, 2'h3, 3'h4, 1'b1, 16'hFFFE}};

	cbsw_branch_unit dut (.*);

	initial
	begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic run_row(input cbsw_row_t r, input logic kn = 1'b1);
		int n;
		int d;
		@(negedge core_clk_i);
		{opcode_i, operand1_i, operand2_i, acc_i, opnd_val_i} = {r.opc, r.o1, r.o2, r.acc, r.val};
		instr_addr_i = r.addr;
		dec_valid_i = 1'b1;
		@(negedge core_clk_i);
		dec_valid_i = 1'b0;
		check("length", 16'(instr_len_o), 16'(r.len));
		check("taken", 16'(taken_o), 16'(r.tk));
		check("target", target_o, r.tgt);
		check("next pc", next_pc_o, r.addr + 16'(r.len));
		check("known", 16'(known_o), 16'(kn));
		n = 0;
		d = 0;
		while (busy_o === 1'b1 && n < 8)
		begin
			n++;
			if (done_o === 1'b1)
				d = n;
			@(negedge core_clk_i);
		end
		check("cycles", 16'(n), 16'(r.cyc));
		check("done cycle", 16'(d), 16'(r.cyc));
	endtask : run_row

	task automatic alu(input cbsw_pkg::cbsw_alu_op_t op, input logic [7:0] a, b,
		input logic cy, ov);
		@(negedge core_clk_i);
		alu_op_i = op;
		{alu_a_i, alu_b_i, alu_valid_i} = {a, b, 1'b1};
		@(negedge core_clk_i);
		alu_valid_i = 1'b0;
		check("carry", 16'(status_word_o[7]), 16'(cy));
		check("overflow", 16'(status_word_o[2]), 16'(ov));
	endtask : alu

	task automatic sf_access(input logic wr, input logic [7:0] a, d);
		@(negedge core_clk_i);
		{sf_wr_i, sf_rd_i, sf_addr_i, sf_wdata_i} = {wr, !wr, a, d};
		@(negedge core_clk_i);
		{sf_wr_i, sf_rd_i} = 2'h0;
		if (!wr)
			check("read data", 16'(sf_rdata_o), 16'(d));
	endtask : sf_access

	task automatic complete_run;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	initial
	begin
		repeat (2000) @(posedge core_clk_i);
		bad_count++;
		complete_run();
	end

	initial
	begin
		{resetn_i, dec_valid_i, alu_valid_i, sf_wr_i, sf_rd_i} = 5'h0;
		{opcode_i, operand1_i, operand2_i, acc_i, opnd_val_i, instr_addr_i} = 56'h0;
		{alu_a_i, alu_b_i, sf_addr_i, sf_wdata_i} = 32'h0;
		alu_op_i = cbsw_pkg::ALU_NONE;
		ptr_val_i = 8'h30;
		repeat (3) @(posedge core_clk_i);
		@(negedge core_clk_i);
		resetn_i = 1'b1;
		check("status reset", 16'(status_word_o), 16'h0000);
		sf_access(1'b0, 8'hD0, 8'h00);
		foreach (rows[i])
			run_row(rows[i]);
		// Unhandled opcode: one byte, one cycle, not known
		run_row(cbsw_row_t'{8'hA4, 8'h00, 8'h00, 8'h00, 8'h00, 16'h2000, 2'h1, 3'h1, 1'b0,
			16'h2001}, 1'b0);
		// Bank three selects the top register block
		sf_access(1'b1, 8'hD0, 8'h18);
		check("status bank", 16'(status_word_o[7:1]), 16'h000C);
		run_row(rows[9]);
		check("bank reg", 16'(op_addr_o), 16'h001B);
		run_row(rows[7]);
		check("pointer reg", 16'(ptr_reg_addr_o), 16'h0019);
		run_row(rows[11]);
		check("special", 16'(op_is_special_o), 16'h0001);
		check("dec result", 16'(dec_result_o), 16'h0001);
		run_row(rows[12]);
		check("data mem", 16'(op_is_special_o), 16'h0000);
		sf_access(1'b1, 8'h50, 8'hFF);
		sf_access(1'b0, 8'h51, 8'h00);
		acc_i = 8'h00;
		sf_access(1'b0, 8'hD0, 8'h18);
		alu(cbsw_pkg::ALU_ADD, 8'h7F, 8'h01, 1'b0, 1'b1);
		alu(cbsw_pkg::ALU_ADD, 8'hFF, 8'h01, 1'b1, 1'b0);
		alu(cbsw_pkg::ALU_SUB_BORROW, 8'h00, 8'h01, 1'b1, 1'b0);
		alu(cbsw_pkg::ALU_MULTIPLY, 8'h10, 8'h10, 1'b0, 1'b1);
		alu(cbsw_pkg::ALU_DIVIDE, 8'h08, 8'h02, 1'b0, 1'b0);
		alu(cbsw_pkg::ALU_DIVIDE, 8'h08, 8'h00, 1'b0, 1'b1);
		alu(cbsw_pkg::ALU_ADD_CARRY, 8'h80, 8'h80, 1'b1, 1'b1);
		alu(cbsw_pkg::ALU_OTHER, 8'h01, 8'h01, 1'b0, 1'b1);
		// Request held high while busy must be ignored
		@(negedge core_clk_i);
		{opcode_i, operand1_i, operand2_i, dec_valid_i} = {8'h02, 8'h56, 8'h78, 1'b1};
		@(negedge core_clk_i);
		opcode_i = 8'h00;
		repeat (2) @(negedge core_clk_i);
		dec_valid_i = 1'b0;
		repeat (3) @(negedge core_clk_i);
		check("held target", target_o, 16'h5678);
		check("held cycles", 16'(cycles_o), 16'h0004);
		// Reset in mid-instruction
		run_row(rows[0]);
		@(negedge core_clk_i);
		{opcode_i, dec_valid_i} = {8'h12, 1'b1};
		@(negedge core_clk_i);
		{resetn_i, dec_valid_i} = 2'h0;
		@(negedge core_clk_i);
		resetn_i = 1'b1;
		check("busy reset", 16'(busy_o), 16'h0000);
		check("known reset", 16'(known_o), 16'h0000);
		check("target reset", target_o, 16'h0000);
		check("status reset", 16'(status_word_o), 16'h0000);
		run_row(rows[2]);
		complete_run();
	end
endmodule : cbsw_branch_unit_tb
